// ### design/pctc_pkg.sv
// constants shared by the performance counter and trace control block
// assumes a 32-bit AHB-Lite slave port decoding the low 12 address bits
package pctc_pkg;

    // register byte offsets, compared against haddr[11:0]
    localparam logic [11:0] OFS_TRACE_STATUS = 12'h0820; // trace unit status, read only
    localparam logic [11:0] OFS_TRACE_CONFIG = 12'h0830; // counter trace configuration
    localparam logic [11:0] OFS_CONTROL = 12'h0900; // counter control
    localparam logic [11:0] OFS_OVERFLOW = 12'h0920; // sticky overflow flags
    localparam logic [11:0] OFS_EVT_SELECT = 12'h0930; // event selections
    localparam logic [11:0] OFS_CYCLE = 12'h0980; // cycle counter value
    localparam logic [11:0] OFS_QUAL0_LO = 12'h0990; // counter 0 qualifier, low word
    localparam logic [11:0] OFS_QUAL0_HI = 12'h0994; // counter 0 qualifier, high word
    localparam logic [11:0] OFS_EVT0 = 12'h0998; // event counter 0 value
    localparam logic [11:0] OFS_QUAL1_LO = 12'h09a0; // counter 1 qualifier, low word
    localparam logic [11:0] OFS_QUAL1_HI = 12'h09a4; // counter 1 qualifier, high word
    localparam logic [11:0] OFS_EVT1 = 12'h09a8; // event counter 1 value

    // trace unit status fields
    localparam int POS_TRACE_IDLE = 8; // trace unit idle
    localparam int POS_TRACE_PRESENT = 0; // counter tracing implemented
    localparam logic TRACE_PRESENT_VAL = 1'b1; // constant, tracing is built in

    // trace configuration fields
    localparam int POS_TRACE_EN = 0; // counter trace enable
    localparam int POS_DELAY_LSB = 1; // snapshot delay low bit
    localparam int POS_DELAY_MSB = 10; // snapshot delay high bit
    localparam logic RST_TRACE_EN = 1'b0; // build-time reset of trace enable
    localparam logic [9:0] RST_DELAY = 10'h000; // build-time reset of snapshot delay

    // control fields
    localparam int POS_IRQ_EN = 30; // overflow interrupt enable
    localparam int POS_OVF_STOP = 29; // stop all counters on overflow
    localparam int POS_EVT1_CLR = 9; // event counter 1 clear request
    localparam int POS_EVT1_RUN = 8; // event counter 1 run
    localparam int POS_EVT0_CLR = 7; // event counter 0 clear request
    localparam int POS_EVT0_RUN = 6; // event counter 0 run
    localparam int POS_CYC_CLR = 5; // cycle counter clear request
    localparam int POS_CYC_RUN = 4; // cycle counter run
    localparam logic [3:0] NUM_EVT_COUNTERS = 4'h2; // event counters, cycle counter excluded

    // overflow flag positions
    localparam int POS_OVF_EVT1 = 2;
    localparam int POS_OVF_EVT0 = 1;
    localparam int POS_OVF_CYC = 0;

    // counter all-ones value
    localparam logic [31:0] COUNT_MAX = 32'hffff_ffff;

    // snapshot sequencer, gray coded along idle -> wait -> emit
    typedef enum logic [1:0] {
        PCTC_TR_IDLE = 2'b00,
        PCTC_TR_WAIT = 2'b01,
        PCTC_TR_EMIT = 2'b11
    } pctc_trace_state_t;

endpackage

// ### design/pctc_counter.sv
// one 32-bit counter with clear, software load and increment
// assumes clear, load and inc come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none

module pctc_counter (
    input wire logic clk, // block clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic clear, // zero the counter
    input wire logic load, // software write of a new value
    input wire logic [31:0] load_data, // value written by software
    input wire logic inc, // count this cycle
    input wire logic hold_max, // stop at all ones instead of wrapping
    output logic [31:0] count, // present value
    output logic wrap // pulse: increment seen at all ones
);

    logic [31:0] count_reg; // held value
    logic [31:0] count_next; // next value

    ////////////////////////////////////////////////////////////////////////////
    // next value: clear beats load beats increment
    always_comb begin
        count_next = count_reg;
        wrap = 1'b0;
        if (clear) begin
            count_next = '0;
        end else if (load) begin
            count_next = load_data;
        end else if (inc) begin
            if (count_reg == pctc_pkg::COUNT_MAX) begin
                wrap = 1'b1;
                // stop-on-overflow parks the value at all ones
                count_next = hold_max ? count_reg : '0;
            end else begin
                count_next = count_reg + 32'h0000_0001;
            end
        end
    end

    // register only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule

`default_nettype wire

// ### design/pctc_top.sv
// performance counter and counter-trace control with an AHB-Lite register slave
// assumes one clock hclk, event hits and snap_ready from logic on hclk
//
// Overview of operation
// - read-only trace idle bit 8, resets 1
// - read-only trace-implemented bit 0, reads 1
// - writable 10-bit snapshot delay, bits 10:1
// - snapshot requests raised only while trace enable set
// - interrupt enable bit 30 raises overflow interrupt
// - stop bit 29 halts counters at all ones
// - stop on overflow clears all run bits
// - run plus clear bit 9 zeroes counter 1
// - event counter 1 counts while bit 8 set
// - run plus clear bit 7 zeroes counter 0
// - event counter 0 counts while bit 6 set
// - run plus clear bit 5 zeroes cycle counter
// - cycle counter advances while bit 4 set
// - run without clear resumes from held value
// - clear request bits self-clear, read zero
// - bits 3:0 report two event counters
// - sticky overflow flags bits 2:0, write-one clears
// - cycle counter 32-bit, readable and writable
// - 8-bit event selections, bits 7:0 and 15:8
// - event counters 32-bit, readable and writable, qualified
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none

module pctc_top (
    input wire logic hclk, // bus and counter clock
    input wire logic hresetn, // asynchronous reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size, words only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic hreadyout, // slave ready
    output logic hresp, // response, always okay
    output logic [31:0] hrdata, // read data
    input wire logic evt0_hit, // selected, qualified event for counter 0
    input wire logic evt1_hit, // selected, qualified event for counter 1
    output logic [7:0] evt0_select, // event code for counter 0
    output logic [7:0] evt1_select, // event code for counter 1
    output logic [63:0] evt0_qualifier, // qualifier for counter 0
    output logic [63:0] evt1_qualifier, // qualifier for counter 1
    input wire logic snap_ready, // trace unit takes a snapshot
    output logic snap_valid, // snapshot request, held until taken
    output logic trace_idle, // trace sequencer idle
    output logic perf_irq // overflow interrupt, level
);

    ////////////////////////////////////////////////////////////////////////////
    // register state

    // bus pipeline
    logic wr_pend_reg, wr_pend_next; // write data phase follows
    logic rd_pend_reg, rd_pend_next; // read wait state follows
    logic [11:0] addr_reg, addr_next; // captured byte offset
    logic hreadyout_reg, hreadyout_next; // slave ready
    logic [31:0] hrdata_reg, hrdata_next; // read data
    logic hresp_reg; // response, never an error

    // configuration and control
    logic trace_en_reg, trace_en_next; // counter trace enable
    logic [9:0] delay_reg, delay_next; // snapshot delay
    logic irq_en_reg, irq_en_next; // overflow interrupt enable
    logic ovf_stop_reg, ovf_stop_next; // stop counting on overflow
    logic evt1_run_reg, evt1_run_next; // counter 1 running
    logic evt0_run_reg, evt0_run_next; // counter 0 running
    logic cycle_run_reg, cycle_run_next; // cycle counter running
    logic [2:0] ovf_reg, ovf_next; // sticky overflow flags
    logic [7:0] sel0_reg, sel0_next; // counter 0 event code
    logic [7:0] sel1_reg, sel1_next; // counter 1 event code
    logic [63:0] qual0_reg, qual0_next; // counter 0 qualifier
    logic [63:0] qual1_reg, qual1_next; // counter 1 qualifier
    logic irq_reg, irq_next; // interrupt level

    // snapshot sequencer
    pctc_pkg::pctc_trace_state_t tr_state_reg, tr_state_next;
    logic [9:0] tr_cnt_reg, tr_cnt_next; // cycles waited
    logic snap_valid_reg, snap_valid_next; // snapshot request
    logic idle_reg, idle_next; // sequencer idle

    // counter hookup
    logic [31:0] cyc_count, evt0_count, evt1_count; // counter values
    logic cyc_wrap, evt0_wrap, evt1_wrap; // increment at all ones
    logic cyc_clear, evt0_clear, evt1_clear; // start with clear
    logic cyc_load, evt0_load, evt1_load; // software load
    logic [2:0] wrap_vec; // wraps as flag bits
    logic any_wrap; // any running counter overflowed

    // decoded write strobes
    logic wr_trace_cfg, wr_ctl, wr_ovf, wr_sel; // register writes
    logic wr_q0lo, wr_q0hi, wr_q1lo, wr_q1hi; // qualifier writes
    logic bus_take; // address phase accepted

    ////////////////////////////////////////////////////////////////////////////
    // read decode, shared by the read path
    function automatic logic [31:0] read_word(input logic [11:0] ofs);
        logic [31:0] w;
        w = 32'h0000_0000; // unmapped and reserved bits read zero
        case (ofs)
            pctc_pkg::OFS_TRACE_STATUS: begin
                w[pctc_pkg::POS_TRACE_IDLE] = idle_reg;
                w[pctc_pkg::POS_TRACE_PRESENT] = pctc_pkg::TRACE_PRESENT_VAL;
            end
            pctc_pkg::OFS_TRACE_CONFIG: begin
                w[pctc_pkg::POS_DELAY_MSB:pctc_pkg::POS_DELAY_LSB] = delay_reg;
                w[pctc_pkg::POS_TRACE_EN] = trace_en_reg;
            end
            pctc_pkg::OFS_CONTROL: begin
                // clear request bits are never stored, so they read zero
                w[pctc_pkg::POS_IRQ_EN] = irq_en_reg;
                w[pctc_pkg::POS_OVF_STOP] = ovf_stop_reg;
                w[pctc_pkg::POS_EVT1_RUN] = evt1_run_reg;
                w[pctc_pkg::POS_EVT0_RUN] = evt0_run_reg;
                w[pctc_pkg::POS_CYC_RUN] = cycle_run_reg;
                w[3:0] = pctc_pkg::NUM_EVT_COUNTERS;
            end
            pctc_pkg::OFS_OVERFLOW: w[2:0] = ovf_reg;
            pctc_pkg::OFS_EVT_SELECT: w[15:0] = {sel1_reg, sel0_reg};
            pctc_pkg::OFS_CYCLE: w = cyc_count;
            pctc_pkg::OFS_QUAL0_LO: w = qual0_reg[31:0];
            pctc_pkg::OFS_QUAL0_HI: w = qual0_reg[63:32];
            pctc_pkg::OFS_EVT0: w = evt0_count;
            pctc_pkg::OFS_QUAL1_LO: w = qual1_reg[31:0];
            pctc_pkg::OFS_QUAL1_HI: w = qual1_reg[63:32];
            pctc_pkg::OFS_EVT1: w = evt1_count;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: writes take no wait state, reads take one so that a read
    // right after a write always sees the committed value
    assign bus_take = hsel && htrans[1] && hready;

    always_comb begin
        wr_pend_next = 1'b0;
        rd_pend_next = 1'b0;
        addr_next = addr_reg;
        hreadyout_next = 1'b1;
        hrdata_next = hrdata_reg;
        if (rd_pend_reg) begin
            // wait state over: present the data
            hrdata_next = read_word(addr_reg);
        end else if (bus_take) begin
            addr_next = {haddr[11:2], 2'b00};
            wr_pend_next = hwrite;
            rd_pend_next = !hwrite;
            hreadyout_next = hwrite; // one wait state for reads
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 12'h000;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h0000_0000;
            hresp_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg <= addr_next;
            hreadyout_reg <= hreadyout_next;
            hrdata_reg <= hrdata_next;
            hresp_reg <= 1'b0;
        end
    end

    // write strobes in the data phase
    assign wr_trace_cfg = wr_pend_reg && (addr_reg == pctc_pkg::OFS_TRACE_CONFIG);
    assign wr_ctl = wr_pend_reg && (addr_reg == pctc_pkg::OFS_CONTROL);
    assign wr_ovf = wr_pend_reg && (addr_reg == pctc_pkg::OFS_OVERFLOW);
    assign wr_sel = wr_pend_reg && (addr_reg == pctc_pkg::OFS_EVT_SELECT);
    assign wr_q0lo = wr_pend_reg && (addr_reg == pctc_pkg::OFS_QUAL0_LO);
    assign wr_q0hi = wr_pend_reg && (addr_reg == pctc_pkg::OFS_QUAL0_HI);
    assign wr_q1lo = wr_pend_reg && (addr_reg == pctc_pkg::OFS_QUAL1_LO);
    assign wr_q1hi = wr_pend_reg && (addr_reg == pctc_pkg::OFS_QUAL1_HI);
    assign cyc_load = wr_pend_reg && (addr_reg == pctc_pkg::OFS_CYCLE);
    assign evt0_load = wr_pend_reg && (addr_reg == pctc_pkg::OFS_EVT0);
    assign evt1_load = wr_pend_reg && (addr_reg == pctc_pkg::OFS_EVT1);

    // a clear only acts when run is written to 1 in the same write
    assign cyc_clear = wr_ctl && hwdata[pctc_pkg::POS_CYC_RUN] && hwdata[pctc_pkg::POS_CYC_CLR];
    assign evt0_clear = wr_ctl && hwdata[pctc_pkg::POS_EVT0_RUN] && hwdata[pctc_pkg::POS_EVT0_CLR];
    assign evt1_clear = wr_ctl && hwdata[pctc_pkg::POS_EVT1_RUN] && hwdata[pctc_pkg::POS_EVT1_CLR];

    ////////////////////////////////////////////////////////////////////////////
    // the three counters; without a clear the held value carries on
    pctc_counter u_cycle (
        .clk(hclk),
        .rst_n(hresetn),
        .clear(cyc_clear),
        .load(cyc_load),
        .load_data(hwdata),
        .inc(cycle_run_reg),
        .hold_max(ovf_stop_reg),
        .count(cyc_count),
        .wrap(cyc_wrap)
    );

    pctc_counter u_evt0 (
        .clk(hclk),
        .rst_n(hresetn),
        .clear(evt0_clear),
        .load(evt0_load),
        .load_data(hwdata),
        .inc(evt0_run_reg && evt0_hit),
        .hold_max(ovf_stop_reg),
        .count(evt0_count),
        .wrap(evt0_wrap)
    );

    pctc_counter u_evt1 (
        .clk(hclk),
        .rst_n(hresetn),
        .clear(evt1_clear),
        .load(evt1_load),
        .load_data(hwdata),
        .inc(evt1_run_reg && evt1_hit),
        .hold_max(ovf_stop_reg),
        .count(evt1_count),
        .wrap(evt1_wrap)
    );

    assign wrap_vec = {evt1_wrap, evt0_wrap, cyc_wrap};
    assign any_wrap = |wrap_vec;

    ////////////////////////////////////////////////////////////////////////////
    // control, flags, selections and interrupt
    always_comb begin
        trace_en_next = trace_en_reg;
        delay_next = delay_reg;
        irq_en_next = irq_en_reg;
        ovf_stop_next = ovf_stop_reg;
        evt1_run_next = evt1_run_reg;
        evt0_run_next = evt0_run_reg;
        cycle_run_next = cycle_run_reg;
        sel0_next = sel0_reg;
        sel1_next = sel1_reg;
        qual0_next = qual0_reg;
        qual1_next = qual1_reg;
        ovf_next = ovf_reg;
        if (wr_trace_cfg) begin
            trace_en_next = hwdata[pctc_pkg::POS_TRACE_EN];
            delay_next = hwdata[pctc_pkg::POS_DELAY_MSB:pctc_pkg::POS_DELAY_LSB];
        end
        if (wr_ctl) begin
            irq_en_next = hwdata[pctc_pkg::POS_IRQ_EN];
            ovf_stop_next = hwdata[pctc_pkg::POS_OVF_STOP];
            evt1_run_next = hwdata[pctc_pkg::POS_EVT1_RUN];
            evt0_run_next = hwdata[pctc_pkg::POS_EVT0_RUN];
            cycle_run_next = hwdata[pctc_pkg::POS_CYC_RUN];
        end
        // hardware stop outranks a software start in the same cycle
        if (ovf_stop_reg && any_wrap) begin
            evt1_run_next = 1'b0;
            evt0_run_next = 1'b0;
            cycle_run_next = 1'b0;
        end
        if (wr_sel) begin
            sel0_next = hwdata[7:0];
            sel1_next = hwdata[15:8];
        end
        if (wr_q0lo) begin
            qual0_next[31:0] = hwdata;
        end
        if (wr_q0hi) begin
            qual0_next[63:32] = hwdata;
        end
        if (wr_q1lo) begin
            qual1_next[31:0] = hwdata;
        end
        if (wr_q1hi) begin
            qual1_next[63:32] = hwdata;
        end
        // write-one clear, then restart clears, then new overflows win
        if (wr_ovf) begin
            ovf_next = ovf_next & ~hwdata[2:0];
        end
        if (cyc_clear) begin
            ovf_next[pctc_pkg::POS_OVF_CYC] = 1'b0;
        end
        if (evt0_clear) begin
            ovf_next[pctc_pkg::POS_OVF_EVT0] = 1'b0;
        end
        if (evt1_clear) begin
            ovf_next[pctc_pkg::POS_OVF_EVT1] = 1'b0;
        end
        ovf_next = ovf_next | wrap_vec;
        // level interrupt follows the flags one cycle later
        irq_next = irq_en_reg && (|ovf_reg);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trace_en_reg <= pctc_pkg::RST_TRACE_EN;
            delay_reg <= pctc_pkg::RST_DELAY;
            irq_en_reg <= 1'b0;
            ovf_stop_reg <= 1'b0;
            evt1_run_reg <= 1'b0;
            evt0_run_reg <= 1'b0;
            cycle_run_reg <= 1'b0;
            sel0_reg <= 8'h00;
            sel1_reg <= 8'h00;
            qual0_reg <= 64'h0000_0000_0000_0000;
            qual1_reg <= 64'h0000_0000_0000_0000;
            ovf_reg <= 3'h0;
            irq_reg <= 1'b0;
        end else begin
            trace_en_reg <= trace_en_next;
            delay_reg <= delay_next;
            irq_en_reg <= irq_en_next;
            ovf_stop_reg <= ovf_stop_next;
            evt1_run_reg <= evt1_run_next;
            evt0_run_reg <= evt0_run_next;
            cycle_run_reg <= cycle_run_next;
            sel0_reg <= sel0_next;
            sel1_reg <= sel1_next;
            qual0_reg <= qual0_next;
            qual1_reg <= qual1_next;
            ovf_reg <= ovf_next;
            irq_reg <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // snapshot sequencer: wait delay cycles, request, repeat while enabled;
    // a request already raised is always finished so the trace unit never
    // sees a snapshot withdrawn
    always_comb begin
        tr_state_next = tr_state_reg;
        tr_cnt_next = tr_cnt_reg;
        snap_valid_next = 1'b0;
        case (tr_state_reg)
            pctc_pkg::PCTC_TR_IDLE: begin
                tr_cnt_next = 10'h000;
                if (trace_en_reg) begin
                    tr_state_next = pctc_pkg::PCTC_TR_WAIT;
                end
            end
            pctc_pkg::PCTC_TR_WAIT: begin
                if (!trace_en_reg) begin
                    tr_state_next = pctc_pkg::PCTC_TR_IDLE;
                end else if (tr_cnt_reg >= delay_reg) begin
                    tr_state_next = pctc_pkg::PCTC_TR_EMIT;
                    snap_valid_next = 1'b1;
                end else begin
                    tr_cnt_next = tr_cnt_reg + 10'h001;
                end
            end
            pctc_pkg::PCTC_TR_EMIT: begin
                if (snap_ready) begin
                    tr_cnt_next = 10'h000;
                    tr_state_next = trace_en_reg ? pctc_pkg::PCTC_TR_WAIT
                                                 : pctc_pkg::PCTC_TR_IDLE;
                end else begin
                    snap_valid_next = 1'b1;
                end
            end
            default: begin
                tr_state_next = pctc_pkg::PCTC_TR_IDLE;
                tr_cnt_next = 10'h000;
            end
        endcase
        idle_next = (tr_state_next == pctc_pkg::PCTC_TR_IDLE);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tr_state_reg <= pctc_pkg::PCTC_TR_IDLE;
            tr_cnt_reg <= 10'h000;
            snap_valid_reg <= 1'b0;
            idle_reg <= 1'b1;
        end else begin
            tr_state_reg <= tr_state_next;
            tr_cnt_reg <= tr_cnt_next;
            snap_valid_reg <= snap_valid_next;
            idle_reg <= idle_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;
    assign evt0_select = sel0_reg;
    assign evt1_select = sel1_reg;
    assign evt0_qualifier = qual0_reg;
    assign evt1_qualifier = qual1_reg;
    assign snap_valid = snap_valid_reg;
    assign trace_idle = idle_reg;
    assign perf_irq = irq_reg;

endmodule

`default_nettype wire

// ### sim/pctc_top_assertions.sv
// bus timing, snapshot handshake and select update checks
// assumes a bind onto pctc_top, one clock hclk
`timescale 1ns/1ns
`default_nettype none
module pctc_checker (
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic [31:0] hrdata, // read data
    input wire logic [7:0] evt0_select, // code 0
    input wire logic snap_valid, // snapshot request
    input wire logic snap_ready, // snapshot taken
    input wire logic trace_idle // sequencer idle
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic take; // transfer accepted at this edge
    assign take = hsel && htrans[1] && hready;
    ////////////////////////////////////////
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait wrong");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bad response");
    a_rdata_holds: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    a_snap_held: assert property (snap_valid && !snap_ready |=> snap_valid)
        else $error("snapshot dropped");
    a_snap_drop: assert property (snap_valid && snap_ready |=> !snap_valid)
        else $error("snapshot stuck");
    a_idle_busy: assert property (snap_valid |-> !trace_idle)
        else $error("idle while busy");
    a_select_cause: assert property ($changed(evt0_select) |->
        $past(take && hwrite && haddr[11:0] == pctc_pkg::OFS_EVT_SELECT, 2))
        else $error("select changed alone");
endmodule
`default_nettype wire

// ### sim/tb_perf_counter_trace_ctrl.sv
// self-checking bench for pctc_top over its bus and event pins
// assumes the checker file is compiled before this one
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_perf_counter_trace_ctrl;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, evt0_hit = 0, evt1_hit = 0;
    logic snap_ready = 0, hreadyout, hresp, snap_valid, trace_idle, perf_irq;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [7:0] evt0_select, evt1_select;
    logic [63:0] q1; // counter 1 qualifier as driven out
    int n_tests = 0, n_mismatch = 0, cyc = 0;
    pctc_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .evt0_hit, .evt1_hit,
        .evt0_select, .evt1_select, .evt0_qualifier(), .evt1_qualifier(q1), .snap_ready,
        .snap_valid, .trace_idle, .perf_irq);
    initial begin
        forever #50 hclk = ~hclk;
    end
    ////////////////////////////////////////
    // one single word transfer, held until the slave is ready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {20'h0_0000, a};
        do @(posedge hclk); while (!hreadyout);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge hclk); while (!hreadyout);
        rd = hrdata;
    endtask
    task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK(n, e, rd)
    endtask
    // k cycles of event on counter i, then quiet
    task automatic hits(input int i, input int k);
        repeat (k) begin {evt1_hit, evt0_hit} <= 2'(1 << i); @(posedge hclk); end
        {evt1_hit, evt0_hit} <= 2'b00; @(posedge hclk);
    endtask
    task automatic t_evt(input int i);
        logic [11:0] a;
        int r;
        a = i ? pctc_pkg::OFS_EVT1 : pctc_pkg::OFS_EVT0;
        r = 6 + 2 * i;
        xfer(1'b1, a, 32'h0000_0007);
        xfer(1'b1, pctc_pkg::OFS_CONTROL, 32'(3 << r));
        rchk("evt clear", a, 32'h0000_0000);
        hits(i, 5);
        rchk("evt run", a, 32'h0000_0005);
        xfer(1'b1, pctc_pkg::OFS_CONTROL, 32'h0000_0000);
        hits(i, 4);
        rchk("evt hold", a, 32'h0000_0005);
        xfer(1'b1, pctc_pkg::OFS_CONTROL, 32'(1 << r));
        hits(i, 3);
        rchk("evt resume", a, 32'h0000_0008);
        rchk("ctl clr", pctc_pkg::OFS_CONTROL, 32'((1 << r) | 2));
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin n_mismatch++; stop_test(); end
    end
    ////////////////////////////////////////
    initial begin
        int n;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("status", pctc_pkg::OFS_TRACE_STATUS, 32'h0000_0101);
        rchk("control", pctc_pkg::OFS_CONTROL, 32'h0000_0002);
        rchk("config", pctc_pkg::OFS_TRACE_CONFIG, 32'h0000_0000);
        rchk("unmapped", 12'hffc, 32'h0000_0000);
        t_evt(0);
        t_evt(1);
        xfer(1'b1, pctc_pkg::OFS_EVT_SELECT, 32'h0000_a55a);
        xfer(1'b1, pctc_pkg::OFS_QUAL1_HI, 32'h1234_5678);
        @(posedge hclk);
        `CHK("sel0", 8'h5a, evt0_select)
        `CHK("sel1", 8'ha5, evt1_select)
        `CHK("qual1", 64'h1234_5678_0000_0000, q1)
        // overflow with stop and interrupt enabled
        xfer(1'b1, pctc_pkg::OFS_CYCLE, 32'hffff_fffd);
        rchk("cycle", pctc_pkg::OFS_CYCLE, 32'hffff_fffd);
        // run without clear so the loaded value carries on to all ones
        xfer(1'b1, pctc_pkg::OFS_CONTROL, 32'h6000_0010);
        repeat (8) @(posedge hclk);
        rchk("cycle max", pctc_pkg::OFS_CYCLE, 32'hffff_ffff);
        rchk("runs off", pctc_pkg::OFS_CONTROL, 32'h6000_0002);
        rchk("flag", pctc_pkg::OFS_OVERFLOW, 32'h0000_0001);
        `CHK("irq on", 1'b1, perf_irq)
        xfer(1'b1, pctc_pkg::OFS_OVERFLOW, 32'h0000_0001);
        rchk("flag clr", pctc_pkg::OFS_OVERFLOW, 32'h0000_0000);
        `CHK("irq off", 1'b0, perf_irq)
        // restart with clear: zero at the write edge, one count before the read samples
        xfer(1'b1, pctc_pkg::OFS_CONTROL, 32'h0000_0030);
        rchk("cyc clear", pctc_pkg::OFS_CYCLE, 32'h0000_0001);
        // snapshot with a stalled trace unit, delay 3
        xfer(1'b1, pctc_pkg::OFS_TRACE_CONFIG, 32'h0000_0007);
        rchk("cfg", pctc_pkg::OFS_TRACE_CONFIG, 32'h0000_0007);
        n = 0;
        while (!snap_valid && n < 50) begin @(posedge hclk); n++; end
        `CHK("snap", 1'b1, snap_valid)
        `CHK("busy", 1'b0, trace_idle)
        repeat (3) @(posedge hclk);
        snap_ready <= 1'b1;
        xfer(1'b1, pctc_pkg::OFS_TRACE_CONFIG, 32'h0000_0000);
        repeat (12) @(posedge hclk);
        `CHK("idle", 1'b1, trace_idle)
        `CHK("no snap", 1'b0, snap_valid)
        stop_test();
    end
endmodule
bind pctc_top pctc_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .evt0_select, .snap_valid, .snap_ready,
    .trace_idle);
`default_nettype wire
